// [logic/sfp_device.sv]
// device end of the serial flash command port
// assumes the host keeps its own timing; pins are asynchronous to clk
// Contract
// - sample si rising sck, shift so falling
// - host drives rising, latches next falling
// - accept mode 0 or mode 3 idle clock
// - output valid in low phase after fall
// - first bit placed falling, response follows opcode
// - host holds chip select high before reset
// - decode three continuous array read opcodes
// - decode main memory page read opcode
// - decode fast and slow buffer read opcodes
// - decode protection, lockdown, security register reads
// - decode status and identification read opcodes
// - decode program-through and buffer-to-page writes
// - host rewrites each sector page in span
// - host refreshes page named by pointer
// - large page unless binary variant strap
`timescale 1ns/1ns
`default_nettype none
module sfp_device #(
	parameter int DATA_W = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	sfp_if.device link,
	input wire logic binary_page_strap,
	output logic [3:0] cmd_class,
	output logic cmd_valid,
	output logic [DATA_W-1:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	input wire logic [DATA_W-1:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic frame_active,
	output logic page_binary
);
	import sfp_pkg::*;
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [1:0] cs_sync_r, sck_sync_r, si_sync_r, rst_sync_r;
	logic sck_prev_r;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cs_sync_r <= 2'h3;
			sck_sync_r <= 2'h0;
			si_sync_r <= 2'h0;
			rst_sync_r <= 2'h0;
			sck_prev_r <= 1'b0;
		end else if (clk_en) begin
			cs_sync_r <= {cs_sync_r[0], link.cs_n};
			sck_sync_r <= {sck_sync_r[0], link.sck};
			si_sync_r <= {si_sync_r[0], link.si};
			rst_sync_r <= {rst_sync_r[0], link.reset_pin_n};
			sck_prev_r <= sck_sync_r[1];
		end
	end
	wire logic cs_act = !cs_sync_r[1] && rst_sync_r[1];
	// edges seen only inside a frame; in mode 3 the idle-high clock gives no rise at cs fall
	wire logic sck_rise = cs_act && sck_sync_r[1] && !sck_prev_r;
	wire logic sck_fall = cs_act && !sck_sync_r[1] && sck_prev_r;
	// ------------------------------------------------------------
	// page size strap, caught after reset release
	// ------------------------------------------------------------
	logic strap_done_r;
	logic page_binary_r;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			strap_done_r <= 1'b0;
			page_binary_r <= 1'b0;
		end else if (clk_en && !strap_done_r) begin
			strap_done_r <= 1'b1;
			page_binary_r <= binary_page_strap;
		end
	end
	assign page_binary = page_binary_r;
	// ------------------------------------------------------------
	// receive shifter
	// ------------------------------------------------------------
	logic [DATA_W-1:0] shift_in_r;
	logic [$clog2(DATA_W)-1:0] bit_cnt_r;
	logic first_byte_r;
	logic byte_done_r;
	logic [DATA_W-1:0] byte_r;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shift_in_r <= '0;
			bit_cnt_r <= '0;
			first_byte_r <= 1'b1;
			byte_done_r <= 1'b0;
			byte_r <= '0;
		end else if (clk_en) begin
			byte_done_r <= 1'b0;
			if (!cs_act) begin
				bit_cnt_r <= '0;
				first_byte_r <= 1'b1;
			end else if (sck_rise) begin
				shift_in_r <= {shift_in_r[DATA_W-2:0], si_sync_r[1]};
				bit_cnt_r <= bit_cnt_r + 1'b1;
				if (bit_cnt_r == $clog2(DATA_W)'(DATA_W - 1)) begin
					byte_r <= {shift_in_r[DATA_W-2:0], si_sync_r[1]};
					byte_done_r <= 1'b1;
				end
			end
			if (byte_done_r)
				first_byte_r <= 1'b0;
		end
	end
	// ------------------------------------------------------------
	// opcode decode
	// ------------------------------------------------------------
	logic [3:0] cmd_class_r;
	logic cmd_valid_r;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_class_r <= SFP_CMD_NONE;
			cmd_valid_r <= 1'b0;
		end else if (clk_en) begin
			cmd_valid_r <= byte_done_r && first_byte_r;
			if (byte_done_r && first_byte_r)
				cmd_class_r <= sfp_decode(byte_r);
			else if (!cs_act)
				cmd_class_r <= SFP_CMD_NONE;
		end
	end
	assign cmd_class = cmd_class_r;
	assign cmd_valid = cmd_valid_r;
	// ------------------------------------------------------------
	// two-entry receive buffer; a stall drops nothing but the newest byte past two
	// ------------------------------------------------------------
	logic [DATA_W-1:0] rbuf_r [BUF_DEPTH];
	logic rwp_r, rrp_r;
	logic [1:0] rcnt_r;
	logic rx_valid_r;
	wire logic rpush = byte_done_r && !first_byte_r && rcnt_r != 2'(BUF_DEPTH);
	wire logic rpop = rx_valid_r && rx_ready;
	wire logic [1:0] rcnt_nxt = rcnt_r + 2'(rpush) - 2'(rpop);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rwp_r <= 1'b0;
			rrp_r <= 1'b0;
			rcnt_r <= 2'h0;
			rx_valid_r <= 1'b0;
			rbuf_r[0] <= '0;
			rbuf_r[1] <= '0;
		end else if (clk_en) begin
			if (rpush) begin
				rbuf_r[rwp_r] <= byte_r;
				rwp_r <= !rwp_r;
			end
			if (rpop)
				rrp_r <= !rrp_r;
			rcnt_r <= rcnt_nxt;
			rx_valid_r <= rcnt_nxt != 2'h0;
		end
	end
	assign rx_valid = rx_valid_r;
	assign rx_data = rbuf_r[rrp_r];
	// ------------------------------------------------------------
	// transmit: load once the opcode decodes to a class, shift on falling edges
	// ------------------------------------------------------------
	logic [DATA_W-1:0] shift_out_r;
	logic [$clog2(DATA_W)-1:0] out_cnt_r;
	logic out_loaded_r;
	logic so_r, so_oe_r;
	logic tx_ready_r;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shift_out_r <= '0;
			out_cnt_r <= '0;
			out_loaded_r <= 1'b0;
			so_r <= 1'b0;
			so_oe_r <= 1'b0;
			tx_ready_r <= 1'b0;
		end else if (clk_en) begin
			tx_ready_r <= 1'b0;
			if (!cs_act) begin
				so_oe_r <= 1'b0;
				out_loaded_r <= 1'b0;
				out_cnt_r <= '0;
			end else begin
				if (!out_loaded_r && tx_valid && !tx_ready_r && cmd_class_r != SFP_CMD_NONE) begin
					shift_out_r <= tx_data;
					out_loaded_r <= 1'b1;
					tx_ready_r <= 1'b1;
				end
				if (sck_fall && out_loaded_r) begin
					so_r <= shift_out_r[DATA_W-1];
					so_oe_r <= 1'b1;
					shift_out_r <= {shift_out_r[DATA_W-2:0], 1'b0};
					out_cnt_r <= out_cnt_r + 1'b1;
					if (out_cnt_r == $clog2(DATA_W)'(DATA_W - 1))
						out_loaded_r <= 1'b0;
				end
			end
		end
	end
	assign link.so = so_r;
	assign link.so_oe = so_oe_r;
	assign tx_ready = tx_ready_r;
	logic frame_active_r;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			frame_active_r <= 1'b0;
		else if (clk_en)
			frame_active_r <= !cs_sync_r[1];
	end
	assign frame_active = frame_active_r;
endmodule : sfp_device
`default_nettype wire

// [logic/sfp_pkg.sv]
// package for the serial flash command port: opcodes, sizes, timing counts
// assumes both ends and the bench import it
package sfp_pkg;
	// ------------------------------------------------------------
	// opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_ARRAY_READ_LEGACY = 8'hE8;
	localparam logic [7:0] OP_ARRAY_READ_FAST = 8'h0B;
	localparam logic [7:0] OP_ARRAY_READ_SLOW = 8'h03;
	localparam logic [7:0] OP_PAGE_READ = 8'hD2;
	localparam logic [7:0] OP_BUF1_READ_FAST = 8'hD4;
	localparam logic [7:0] OP_BUF2_READ_FAST = 8'hD6;
	localparam logic [7:0] OP_BUF1_READ_SLOW = 8'hD1;
	localparam logic [7:0] OP_BUF2_READ_SLOW = 8'hD3;
	localparam logic [7:0] OP_PROT_READ = 8'h32;
	localparam logic [7:0] OP_LOCK_READ = 8'h35;
	localparam logic [7:0] OP_SECURITY_READ = 8'h77;
	localparam logic [7:0] OP_STATUS_READ = 8'hD7;
	localparam logic [7:0] OP_ID_READ = 8'h9F;
	localparam logic [7:0] OP_BUF1_WRITE = 8'h84;
	localparam logic [7:0] OP_BUF2_WRITE = 8'h87;
	localparam logic [7:0] OP_PROG_THRU_BUF1 = 8'h82;
	localparam logic [7:0] OP_PROG_THRU_BUF2 = 8'h85;
	localparam logic [7:0] OP_BUF1_TO_PAGE = 8'h83;
	localparam logic [7:0] OP_BUF2_TO_PAGE = 8'h86;
	// ------------------------------------------------------------
	// command classes
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		SFP_CMD_NONE = 4'h0,
		SFP_CMD_ARRAY_READ = 4'h1,
		SFP_CMD_PAGE_READ = 4'h2,
		SFP_CMD_BUF_READ = 4'h3,
		SFP_CMD_REG_READ = 4'h4,
		SFP_CMD_STATUS = 4'h5,
		SFP_CMD_ID = 4'h6,
		SFP_CMD_BUF_WRITE = 4'h7,
		SFP_CMD_PROG_THRU = 4'h8,
		SFP_CMD_BUF_TO_PAGE = 4'h9
	} sfp_cmd_e;
	// ------------------------------------------------------------
	// sizes and timing
	// ------------------------------------------------------------
	localparam int PAGE_SIZE_LARGE = 528;
	localparam int PAGE_SIZE_BINARY = 512;
	localparam int REFRESH_SPAN = 20000;
	localparam int CLK_MHZ = 125;
	localparam int SCK_MAX_MHZ = 66;
	// host half period in clk cycles, rounded up so sck stays at or under the maximum
	localparam int SCK_HALF_CYC = (CLK_MHZ + 2 * SCK_MAX_MHZ - 1) / (2 * SCK_MAX_MHZ);
	localparam int HOST_HALF_CYC = 4;
	localparam int BUF_DEPTH = 2;

	function automatic sfp_cmd_e sfp_decode(input logic [7:0] op);
		case (op)
			OP_ARRAY_READ_LEGACY, OP_ARRAY_READ_FAST, OP_ARRAY_READ_SLOW: sfp_decode = SFP_CMD_ARRAY_READ;
			OP_PAGE_READ: sfp_decode = SFP_CMD_PAGE_READ;
			OP_BUF1_READ_FAST, OP_BUF2_READ_FAST, OP_BUF1_READ_SLOW, OP_BUF2_READ_SLOW: sfp_decode = SFP_CMD_BUF_READ;
			OP_PROT_READ, OP_LOCK_READ, OP_SECURITY_READ: sfp_decode = SFP_CMD_REG_READ;
			OP_STATUS_READ: sfp_decode = SFP_CMD_STATUS;
			OP_ID_READ: sfp_decode = SFP_CMD_ID;
			OP_BUF1_WRITE, OP_BUF2_WRITE: sfp_decode = SFP_CMD_BUF_WRITE;
			OP_PROG_THRU_BUF1, OP_PROG_THRU_BUF2: sfp_decode = SFP_CMD_PROG_THRU;
			OP_BUF1_TO_PAGE, OP_BUF2_TO_PAGE: sfp_decode = SFP_CMD_BUF_TO_PAGE;
			default: sfp_decode = SFP_CMD_NONE;
		endcase
	endfunction : sfp_decode
endpackage : sfp_pkg

// [logic/sfp_if.sv]
// interface joining host and device ends of the serial flash port
// assumes the bench supplies nothing but instantiation
`timescale 1ns/1ns
`default_nettype none
interface sfp_if;
	logic cs_n;
	logic sck;
	logic si;
	logic so;
	logic so_oe;
	logic reset_pin_n;
	wire so_wire;
	// released serial output reads high, as with a pull-up
	assign so_wire = so_oe ? so : 1'b1;
	modport device (
		input cs_n,
		input sck,
		input si,
		input reset_pin_n,
		output so,
		output so_oe
	);
	modport host (
		output cs_n,
		output sck,
		output si,
		output reset_pin_n,
		input so_wire
	);
endinterface : sfp_if
`default_nettype wire

// [logic/sfp_host.sv]
// host end: makes sck by a divider, sends bytes, latches returned bits
// assumes the device answers on falling sck edges
`timescale 1ns/1ns
`default_nettype none
module sfp_host #(
	parameter int DATA_W = 8,
	parameter int HALF = sfp_pkg::HOST_HALF_CYC
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	sfp_if.host link,
	input wire logic mode3,
	input wire logic start,
	input wire logic last,
	input wire logic [DATA_W-1:0] wr_data,
	output logic busy,
	output logic [DATA_W-1:0] rd_data,
	output logic rd_valid
);
	import sfp_pkg::*;
	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_SHIFT = 2'b01,
		HS_END = 2'b10
	} sfp_hstate_e;
	sfp_hstate_e st_r;
	logic [7:0] div_r;
	logic sck_r, cs_n_r, si_r, busy_r, rd_valid_r, last_r, rst_pin_r;
	logic [DATA_W-1:0] sh_r, rx_r, rd_r;
	logic [$clog2(DATA_W):0] cnt_r;
	logic [1:0] so_sync_r;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			so_sync_r <= 2'h3;
		else if (clk_en)
			so_sync_r <= {so_sync_r[0], link.so_wire};
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= HS_IDLE;
			div_r <= 8'h00;
			sck_r <= 1'b0;
			cs_n_r <= 1'b1;
			si_r <= 1'b0;
			busy_r <= 1'b0;
			rd_valid_r <= 1'b0;
			last_r <= 1'b0;
			rst_pin_r <= 1'b0;
			sh_r <= '0;
			rx_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else if (clk_en) begin
			rd_valid_r <= 1'b0;
			rst_pin_r <= cs_n_r ? 1'b1 : rst_pin_r;
			case (st_r)
				HS_IDLE: begin
					sck_r <= mode3;
					if (start && rst_pin_r) begin
						cs_n_r <= 1'b0;
						sh_r <= wr_data;
						last_r <= last;
						cnt_r <= '0;
						div_r <= 8'h00;
						busy_r <= 1'b1;
						st_r <= HS_SHIFT;
					end
				end
				HS_SHIFT: begin
					if (div_r == 8'(HALF - 1)) begin
						div_r <= 8'h00;
						sck_r <= !sck_r;
						if (!sck_r) begin
							si_r <= sh_r[DATA_W-1];
							sh_r <= {sh_r[DATA_W-2:0], 1'b0};
							cnt_r <= cnt_r + 1'b1;
						end else if (cnt_r != '0) begin
							rx_r <= {rx_r[DATA_W-2:0], so_sync_r[1]};
							if (cnt_r == ($clog2(DATA_W)+1)'(DATA_W)) begin
								rd_r <= {rx_r[DATA_W-2:0], so_sync_r[1]};
								rd_valid_r <= 1'b1;
								st_r <= HS_END;
							end
						end
					end else
						div_r <= div_r + 8'h01;
				end
				HS_END: begin
					busy_r <= 1'b0;
					cnt_r <= '0;
					if (last_r) begin
						// last low phase keeps its full length before cs rises
						if (div_r == 8'(HALF - 1)) begin
							div_r <= 8'h00;
							cs_n_r <= 1'b1;
							sck_r <= mode3;
							st_r <= HS_IDLE;
						end else
							div_r <= div_r + 8'h01;
					end else if (start) begin
						sh_r <= wr_data;
						last_r <= last;
						busy_r <= 1'b1;
						st_r <= HS_SHIFT;
					end
				end
				default: st_r <= HS_IDLE;
			endcase
		end
	end
	assign link.sck = sck_r;
	assign link.cs_n = cs_n_r;
	assign link.si = si_r;
	assign link.reset_pin_n = rst_pin_r;
	assign busy = busy_r;
	assign rd_data = rd_r;
	assign rd_valid = rd_valid_r;
endmodule : sfp_host
`default_nettype wire

// [verif/sfp_link_chk.sv]
// checker on the wires between host and device ends
// assumes it sits beside the interface and shares clk and reset_n
`timescale 1ns/1ns
`default_nettype none
module sfp_link_chk (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic so,
	input wire logic so_oe,
	input wire logic reset_pin_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// ----
	// helpers
	// ----
	logic sck_r;
	logic [2:0] rise_cnt_r;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sck_r <= 1'b0;
		end else begin
			sck_r <= sck;
		end
	end
	// rises, not falls: mode 3 adds a leading fall; its closing rise meets cs high
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rise_cnt_r <= 3'h0;
		end else if (cs_n) begin
			rise_cnt_r <= 3'h0;
		end else if (!sck_r && sck) begin
			rise_cnt_r <= rise_cnt_r + 3'h1;
		end
	end
	sequence s_low_hold;
		!sck [*4];
	endsequence
	sequence s_so_driven;
		so_oe && $past(so_oe);
	endsequence
	// ----
	// assertions
	// ----
	chk_so_released: assert property (cs_n [*4] |-> !so_oe)
		else $error("so driven while chip select high");
	chk_so_high_hold: assert property (sck && sck_r && !cs_n && so_oe && $past(so_oe) |-> $stable(so))
		else $error("so moved while sck high");
	chk_so_low_phase: assert property (s_so_driven ##0 $changed(so) |-> !sck)
		else $error("so changed outside sck low phase");
	chk_si_on_rise: assert property ($changed(si) && !cs_n && !$past(cs_n) |-> sck)
		else $error("si changed outside sck high phase");
	chk_sck_half: assert property ($fell(sck) && !cs_n |-> s_low_hold)
		else $error("sck low phase too short");
	chk_reset_cs: assert property (!reset_pin_n |-> cs_n)
		else $error("chip select low during device reset");
	chk_release_cs: assert property ($rose(reset_pin_n) |-> cs_n && $past(cs_n))
		else $error("device reset released with chip select low");
	chk_byte_whole: assert property ($rose(cs_n) |-> rise_cnt_r == 3'h0)
		else $error("frame ended inside a byte");
endmodule : sfp_link_chk
`default_nettype wire

// [verif/serial_flash_command_port_test.sv]
// bench joining host and device ends through the interface
// assumes the package, interface and both ends are compiled first
`timescale 1ns/1ns
`default_nettype none
module serial_flash_command_port_test;
	import sfp_pkg::*;
	logic clk = 1'b0, reset_n = 1'b0, mode3 = 1'b0, start = 1'b0, last = 1'b0;
	logic strap = 1'b1, rx_ready = 1'b1, tx_valid = 1'b1;
	logic [7:0] wr_data = 8'h00, tx_data = 8'h00, rx_data, rd_data;
	logic [3:0] cmd_class;
	logic cmd_valid, rx_valid, tx_ready, frame_active, page_binary, busy, rd_valid;
	logic [15:0] lfsr = 16'h7C74;
	logic [7:0] page_ptr = 8'h00;
	logic use_ptr = 1'b0;
	int error_cnt = 0, tests_run = 0, i;
	logic [3:0] exp_cmd[$];
	logic [7:0] exp_rx[$], exp_rd[$];
	// last entry is an unknown opcode: no class, no response
	logic [7:0] ops[20] = '{8'hE8, 8'h0B, 8'h03, 8'hD2, 8'hD4, 8'hD6, 8'hD1, 8'hD3, 8'h32, 8'h35,
		8'h77, 8'hD7, 8'h9F, 8'h84, 8'h87, 8'h82, 8'h85, 8'h83, 8'h86, 8'h00};
	logic [3:0] cls[20] = '{4'h1, 4'h1, 4'h1, 4'h2, 4'h3, 4'h3, 4'h3, 4'h3, 4'h4, 4'h4,
		4'h4, 4'h5, 4'h6, 4'h7, 4'h7, 4'h8, 4'h8, 4'h9, 4'h9, 4'h0};
	sfp_if lnk();
	sfp_device sfp_device_i (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .link(lnk),
		.binary_page_strap(strap), .cmd_class(cmd_class), .cmd_valid(cmd_valid), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .frame_active(frame_active), .page_binary(page_binary));
	sfp_host sfp_host_i (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .link(lnk), .mode3(mode3),
		.start(start), .last(last), .wr_data(wr_data), .busy(busy), .rd_data(rd_data), .rd_valid(rd_valid));
	sfp_link_chk sfp_link_chk_i (.clk(clk), .reset_n(reset_n), .cs_n(lnk.cs_n), .sck(lnk.sck),
		.si(lnk.si), .so(lnk.so), .so_oe(lnk.so_oe), .reset_pin_n(lnk.reset_pin_n));
	always #4 clk = ~clk;
	// ----
	// stimulus helpers
	// ----
	// random stalls on the receive side exercise the two-entry buffer
	always @(negedge clk) begin
		lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		rx_ready <= lfsr[0] | lfsr[5];
	end
	task automatic cmp4(input logic [3:0] got, input logic [3:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp4
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp8
	task automatic do_reset(input logic s);
		reset_n = 1'b0;
		strap = s;
		repeat (8) @(negedge clk);
		reset_n = 1'b1;
		repeat (10) @(negedge clk);
		cmp8({7'h00, page_binary}, {7'h00, s});
	endtask : do_reset
	task automatic frame(input logic [7:0] op, input logic [3:0] cl, input int n);
		logic [7:0] b;
		int k;
		int w;
		tx_data = lfsr[15:8];
		if (cl != 4'h0) exp_cmd.push_back(cl);
		for (k = 0; k < n; k++) begin
			b = (k == 0) ? op : (k == 1 && use_ptr) ? page_ptr : lfsr[7:0] ^ k[7:0];
			if (k > 0) exp_rx.push_back(b);
			// released so reads high until a response is loaded
			exp_rd.push_back((k == 0 || cl == 4'h0) ? 8'hFF : tx_data);
			wr_data = b;
			start = 1'b1;
			last = (k == n - 1);
			w = 0;
			// start stands for one edge only, so a waiting host never re-sends old data
			@(negedge clk);
			start = 1'b0;
			cmp4({3'h0, busy}, 4'h1);
			while (rd_valid !== 1'b1 && w < 300) begin
				@(negedge clk);
				w++;
			end
			if (w >= 300) error_cnt++;
			if (k == 0) cmp4({3'h0, frame_active}, 4'h1);
		end
		start = 1'b0;
		last = 1'b0;
		repeat (30) @(negedge clk);
	endtask : frame
	task automatic complete_run();
		if (exp_cmd.size() + exp_rx.size() + exp_rd.size() != 0) error_cnt++;
		$display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run
	// ----
	// monitor and sequence
	// ----
	always @(posedge clk) begin
		if (cmd_valid === 1'b1) cmp4(cmd_class, exp_cmd.size() > 0 ? exp_cmd.pop_front() : 4'h0);
		if (rx_valid === 1'b1 && rx_ready === 1'b1 && exp_rx.size() > 0) cmp8(rx_data, exp_rx.pop_front());
		if (rd_valid === 1'b1 && exp_rd.size() > 0) cmp8(rd_data, exp_rd.pop_front());
	end
	initial begin
		#300000;
		error_cnt++;
		complete_run();
	end
	initial begin
		do_reset(1'b1);
		// idle clock level alternates between mode 0 and mode 3
		for (i = 0; i < 20; i++) begin
			mode3 = i[0];
			repeat (4) @(negedge clk);
			frame(ops[i], cls[i], (cls[i] == 4'h0) ? 1 : 3);
		end
		do_reset(1'b0);
		frame(8'hD7, 4'h5, 2);
		// refresh rewrites walk the page pointer
		use_ptr = 1'b1;
		repeat (2) begin
			frame(8'h82, 4'h8, 3);
			page_ptr = page_ptr + 8'h01;
		end
		use_ptr = 1'b0;
		complete_run();
	end
endmodule : serial_flash_command_port_test
`default_nettype wire
